// ===== include/nfc_consts.vh
// Constants for the NAND flash host controller: register map, fields, commands and pin timing.
// Assumes a 10 MHz ref_clk; all pin timing counts are in ref_clk cycles.
`ifndef NFC_CONSTS_VH
`define NFC_CONSTS_VH

`define NFC_CLK_MHZ 10
`define NFC_CLK_NS 100
// Register byte offsets on AHB-Lite.
`define NFC_OFF_CTRL 8'h00
`define NFC_OFF_ADDR 8'h04
`define NFC_OFF_WDATA 8'h08
`define NFC_OFF_RDATA 8'h0C
`define NFC_OFF_STAT 8'h10
// Control word fields.
`define NFC_CTRL_OP_LSB 0
`define NFC_CTRL_OP_MSB 2
`define NFC_CTRL_CMD_LSB 8
`define NFC_CTRL_CMD_MSB 15
`define NFC_CTRL_WP_BIT 16
`define NFC_CTRL_X16_BIT 17
`define NFC_CTRL_HOLD_BIT 18
// Operations started by a control write.
`define NFC_OP_CMD 3'h1
`define NFC_OP_ADDR 3'h2
`define NFC_OP_WR 3'h3
`define NFC_OP_RD 3'h4
`define NFC_OP_DESEL 3'h5
// Status word fields.
`define NFC_ST_BUSY_BIT 0
`define NFC_ST_RB_BIT 1
`define NFC_ST_WP_BIT 2
// Command codes.
`define NFC_CMD_READ0 8'h00
`define NFC_CMD_READ1 8'h01
`define NFC_CMD_SPARE 8'h50
`define NFC_CMD_DIN 8'h80
`define NFC_CMD_PROG 8'h10
`define NFC_CMD_ERASE1 8'h60
`define NFC_CMD_ERASE2 8'hD0
`define NFC_CMD_STATUS 8'h70
`define NFC_CMD_RESET 8'hFF
`define NFC_CMD_ID 8'h90
// Status byte bits returned by the device.
`define NFC_SB_FAIL_BIT 0
`define NFC_SB_READY_BIT 6
`define NFC_SB_NOTPROT_BIT 7
// Array geometry.
`define NFC_PAGE_BYTES 528
`define NFC_MAIN_BYTES 512
`define NFC_SPARE_BYTES 16
`define NFC_PAGE_WORDS 264
`define NFC_MAIN_WORDS 256
`define NFC_SPARE_WORDS 8
`define NFC_PAGES_PER_BLOCK 32
`define NFC_BLOCKS 2048
`define NFC_MAX_PROGS 3
// Pin timing in ns and derived cycle counts (least times rounded up).
`define NFC_T_STROBE_NS 50
`define NFC_STROBE_CYC ((`NFC_T_STROBE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_T_ACCESS_NS 35
`define NFC_ACCESS_CYC ((`NFC_T_ACCESS_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_T_SEL_HOLD_NS 100
`define NFC_SEL_HOLD_CYC ((`NFC_T_SEL_HOLD_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// ===== src/nfc_host.v
// NAND flash host controller: drives the flash pins from AHB-Lite registers.
// Assumes flash pin inputs are synchronous to ref_clk and ready_busy_n has an external pull-up.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "nfc_consts.vh"

module nfc_host (
  input wire ref_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output reg cmd_latch_en,
  output reg addr_latch_en,
  output reg chip_sel_n,
  output reg write_strobe_n,
  output reg output_strobe_n,
  output reg write_protect_n,
  input wire [15:0] io_in,
  output reg [15:0] io_out,
  output reg io_oe,
  input wire ready_busy_n
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WLOW = 3'h1;
  localparam [2:0] ST_WHIGH = 3'h2;
  localparam [2:0] ST_RLOW = 3'h3;
  localparam [2:0] ST_RHIGH = 3'h4;
  localparam [2:0] ST_DESEL = 3'h5;
  localparam [31:0] STROBE_CYC_W = `NFC_STROBE_CYC;
  localparam [31:0] ACCESS_CYC_W = `NFC_ACCESS_CYC;
  localparam [31:0] SEL_HOLD_CYC_W = `NFC_SEL_HOLD_CYC;
  localparam [31:0] MAX_PROGS_W = `NFC_MAX_PROGS;
  localparam [3:0] STROBE_CYC = STROBE_CYC_W[3:0];
  localparam [3:0] ACCESS_CYC = ACCESS_CYC_W[3:0];
  localparam [3:0] SEL_HOLD_CYC = SEL_HOLD_CYC_W[3:0];
  localparam [1:0] MAX_PROGS = MAX_PROGS_W[1:0];

  // True when a command code may be issued while the device reports busy.
  function busy_ok;
    input [7:0] code;
    begin
      busy_ok = (code == `NFC_CMD_RESET) || (code == `NFC_CMD_STATUS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave.

  reg ap_valid_r;
  reg ap_write_r;
  reg [7:0] ap_addr_r;
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [2:0] op_r;
  reg [7:0] cmd_r;
  reg x16_r;
  reg hold_r;
  reg [23:0] addr_r;
  reg [1:0] addr_idx_r;
  reg [15:0] wdata_r;
  reg [15:0] rdata_r;
  reg refused_r;
  reg [15:0] prog_page_r;
  reg [1:0] prog_cnt_r;
  reg [31:0] hrdata_nxt;

  wire busy = (state_r != ST_IDLE);
  wire ap_take = hsel && hready && htrans[1];
  wire wr_ctrl = ap_valid_r && ap_write_r && (ap_addr_r == `NFC_OFF_CTRL);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  always @* begin
    if (haddr[7:0] == `NFC_OFF_CTRL)
      hrdata_nxt = {13'h0, hold_r, x16_r, write_protect_n, cmd_r, 5'h00, op_r};
    else if (haddr[7:0] == `NFC_OFF_ADDR)
      hrdata_nxt = {8'h00, addr_r};
    else if (haddr[7:0] == `NFC_OFF_WDATA)
      hrdata_nxt = {16'h0000, wdata_r};
    else if (haddr[7:0] == `NFC_OFF_RDATA)
      hrdata_nxt = {16'h0000, rdata_r};
    else if (haddr[7:0] == `NFC_OFF_STAT)
      hrdata_nxt = {28'h0, refused_r, write_protect_n, ready_busy_n, busy};
    else
      hrdata_nxt = 32'h00000000;
  end

  // Read data is captured in the address phase and stands through the data phase.
  // A read straight after a write to the same register returns the value from before that write.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (ap_take && !hwrite)
      hrdata <= hrdata_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin sequencer.

  // A control write while a cycle runs is dropped; software polls the busy bit first.
  wire start = wr_ctrl && !busy;
  wire [2:0] new_op = hwdata[`NFC_CTRL_OP_MSB:`NFC_CTRL_OP_LSB];
  wire [7:0] new_cmd = hwdata[`NFC_CTRL_CMD_MSB:`NFC_CTRL_CMD_LSB];
  // Of the commands, only reset and status may go while the device is busy.
  wire cmd_block = (new_op == `NFC_OP_CMD) && !ready_busy_n && !busy_ok(new_cmd);
  // Only the last programmed page is tracked, so software must keep the limit for others.
  wire prog_limit = (new_op == `NFC_OP_CMD) && (new_cmd == `NFC_CMD_PROG) &&
                    (addr_r[23:8] == prog_page_r) && (prog_cnt_r == MAX_PROGS);
  wire refuse = cmd_block || prog_limit;
  // Address bytes sent in order A0-A7, A9-A16, A17-A24; A8 comes from the read command.
  wire [7:0] addr_byte = (addr_idx_r == 2'd0) ? addr_r[7:0] :
                         (addr_idx_r == 2'd1) ? addr_r[15:8] : addr_r[23:16];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      op_r <= 3'h0;
      cmd_r <= 8'h00;
      x16_r <= 1'b0;
      hold_r <= 1'b0;
      addr_r <= 24'h000000;
      addr_idx_r <= 2'd0;
      wdata_r <= 16'h0000;
      rdata_r <= 16'h0000;
      refused_r <= 1'b0;
      prog_page_r <= 16'h0000;
      prog_cnt_r <= 2'd0;
      cmd_latch_en <= 1'b0;
      addr_latch_en <= 1'b0;
      chip_sel_n <= 1'b1;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      write_protect_n <= 1'b0;
      io_out <= 16'h0000;
      io_oe <= 1'b0;
    end else begin
      if (ap_valid_r && ap_write_r && ap_addr_r == `NFC_OFF_ADDR && !busy) begin
        addr_r <= hwdata[23:0];
        addr_idx_r <= 2'd0;
      end
      if (ap_valid_r && ap_write_r && ap_addr_r == `NFC_OFF_WDATA && !busy)
        wdata_r <= hwdata[15:0];
      if (wr_ctrl && !busy) begin
        write_protect_n <= hwdata[`NFC_CTRL_WP_BIT];
        x16_r <= hwdata[`NFC_CTRL_X16_BIT];
        hold_r <= hwdata[`NFC_CTRL_HOLD_BIT];
      end
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            op_r <= new_op;
            refused_r <= refuse;
            cnt_r <= STROBE_CYC;
            if (new_op == `NFC_OP_CMD && !refuse) begin
              cmd_r <= new_cmd;
              if (new_cmd == `NFC_CMD_PROG) begin
                prog_cnt_r <= (addr_r[23:8] == prog_page_r) ? prog_cnt_r + 2'd1 : 2'd1;
                prog_page_r <= addr_r[23:8];
              end else if (new_cmd == `NFC_CMD_ERASE2) begin
                prog_cnt_r <= 2'd0;
              end
              chip_sel_n <= 1'b0;
              cmd_latch_en <= 1'b1;
              addr_latch_en <= 1'b0;
              write_strobe_n <= 1'b0;
              io_out <= {8'h00, new_cmd};
              io_oe <= 1'b1;
              state_r <= ST_WLOW;
            end else if (new_op == `NFC_OP_ADDR) begin
              chip_sel_n <= 1'b0;
              cmd_latch_en <= 1'b0;
              addr_latch_en <= 1'b1;
              write_strobe_n <= 1'b0;
              io_out <= {8'h00, addr_byte};
              io_oe <= 1'b1;
              addr_idx_r <= (addr_idx_r == 2'd2) ? 2'd0 : addr_idx_r + 2'd1;
              state_r <= ST_WLOW;
            end else if (new_op == `NFC_OP_WR) begin
              chip_sel_n <= 1'b0;
              cmd_latch_en <= 1'b0;
              addr_latch_en <= 1'b0;
              write_strobe_n <= 1'b0;
              io_out <= x16_r ? wdata_r : {8'h00, wdata_r[7:0]};
              io_oe <= 1'b1;
              state_r <= ST_WLOW;
            end else if (new_op == `NFC_OP_RD && ready_busy_n) begin
              // A read asked for while the device is busy is dropped, so the page transfer is never cut short.
              chip_sel_n <= 1'b0;
              cmd_latch_en <= 1'b0;
              addr_latch_en <= 1'b0;
              output_strobe_n <= 1'b0;
              io_oe <= 1'b0;
              cnt_r <= ACCESS_CYC;
              state_r <= ST_RLOW;
            end else if (new_op == `NFC_OP_DESEL) begin
              // Select high long enough ends a sequential read and enters standby.
              chip_sel_n <= 1'b1;
              cnt_r <= SEL_HOLD_CYC;
              state_r <= ST_DESEL;
            end
          end else if (!hold_r && ready_busy_n && !chip_sel_n && !cmd_latch_en && !addr_latch_en) begin
            // Select is kept low while busy, so a read transfer completes.
            chip_sel_n <= 1'b1;
          end
        end
        ST_WLOW: begin
          if (cnt_r <= 4'h1) begin
            write_strobe_n <= 1'b1;
            cnt_r <= STROBE_CYC;
            state_r <= ST_WHIGH;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_WHIGH: begin
          if (cnt_r <= 4'h1) begin
            cmd_latch_en <= 1'b0;
            addr_latch_en <= 1'b0;
            io_oe <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_RLOW: begin
          if (cnt_r <= 4'h1) begin
            // Word is sampled once the access delay has passed.
            rdata_r <= x16_r ? io_in : {8'h00, io_in[7:0]};
            output_strobe_n <= 1'b1;
            cnt_r <= STROBE_CYC;
            state_r <= ST_RHIGH;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_RHIGH: begin
          if (cnt_r <= 4'h1)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 4'h1;
        end
        ST_DESEL: begin
          if (cnt_r <= 4'h1)
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 4'h1;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // nfc_host

// ===== test/nfc_host_monitor.sv
// Checker on the flash-side ports of nfc_host, attached by bind.
// Assumes one ref_clk domain and the asynchronous active-low rst_n.
`timescale 1ns/1ps
module nfc_host_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire cmd_latch_en,
  input wire addr_latch_en,
  input wire chip_sel_n,
  input wire write_strobe_n,
  input wire output_strobe_n,
  input wire [15:0] io_out,
  input wire io_oe,
  input wire ready_busy_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  sequence s_ws_low;
    !write_strobe_n ##1 write_strobe_n;
  endsequence
  sequence s_os_low;
    (write_strobe_n && !io_oe) ##1 output_strobe_n;
  endsequence
  property p_ws_width; $fell(write_strobe_n) |-> s_ws_low; endproperty
  a_ws_width: assert property (p_ws_width) else $error("write strobe width wrong");
  property p_os_width; $fell(output_strobe_n) |-> s_os_low; endproperty
  a_os_width: assert property (p_os_width) else $error("output strobe width wrong");
  property p_oe_ws; !write_strobe_n |-> io_oe; endproperty
  a_oe_ws: assert property (p_oe_ws) else $error("bus not driven during write");
  property p_cs_ws; !write_strobe_n |-> !chip_sel_n; endproperty
  a_cs_ws: assert property (p_cs_ws) else $error("write strobe without select");
  property p_excl; !(cmd_latch_en && addr_latch_en); endproperty
  a_excl: assert property (p_excl) else $error("both latch enables high");
  property p_upper; io_oe && (cmd_latch_en || addr_latch_en) |-> io_out[15:8] == 8'h00; endproperty
  a_upper: assert property (p_upper) else $error("upper lines not low");
  property p_cs_busy; $rose(chip_sel_n) |-> $past(ready_busy_n); endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("select released while busy");
  property p_busy_cmd;
    $fell(write_strobe_n) && cmd_latch_en && !ready_busy_n |-> io_out[7:0] == 8'hFF || io_out[7:0] == 8'h70;
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("command sent while busy");
  property p_rd_busy; $fell(output_strobe_n) |-> $past(ready_busy_n) && !chip_sel_n; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read strobe while busy");
  property p_cs_os; $rose(chip_sel_n) |-> $past(output_strobe_n); endproperty
  a_cs_os: assert property (p_cs_os) else $error("select rose straight after read strobe");
endmodule // nfc_host_monitor
bind nfc_host nfc_host_monitor i_nfc_host_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_latch_en(cmd_latch_en),
  .addr_latch_en(addr_latch_en), .chip_sel_n(chip_sel_n), .write_strobe_n(write_strobe_n),
  .output_strobe_n(output_strobe_n), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n));

// ===== test/nfc_flash_model.sv
// Behavioural flash on the host pins: latches, a small page buffer, ready/busy and status.
// Assumes the bench resolves the shared bus; the pulled-up ready/busy line is modelled as a plain level.
`timescale 1ns/1ps
module nfc_flash_model #(
  parameter int BUSY_NS = 6000,
  parameter int ACC_NS = 35
) (
  input wire logic chip_sel_n,
  input wire logic cmd_latch_en,
  input wire logic addr_latch_en,
  input wire logic write_strobe_n,
  input wire logic output_strobe_n,
  input wire logic write_protect_n,
  input wire logic [15:0] bus,
  output logic [15:0] dq,
  output logic ready_busy_n
);
  logic [7:0] cmd = 8'h00;
  logic [23:0] adr = 24'h0;
  logic [1:0] acnt = 2'h0;
  logic [7:0] col = 8'h00;
  logic a8 = 1'b0;
  // Only 16 columns of each page half are kept; the bench never strays past them.
  logic [15:0] mem [0:31];
  initial begin
    dq = 16'hFFFF;
    ready_busy_n = 1'b1;
  end
  task automatic go_busy();
    ready_busy_n = 1'b0;
    ready_busy_n <= #(BUSY_NS) 1'b1;
  endtask
  always @(posedge write_strobe_n) begin
    if (!chip_sel_n && cmd_latch_en) begin
      cmd = bus[7:0];
      acnt = 2'h0;
      if (cmd == 8'h00 || cmd == 8'h01)
        a8 = cmd[0];
      if (cmd == 8'h10 && write_protect_n)
        go_busy();
    end else if (!chip_sel_n && addr_latch_en) begin
      adr[acnt*8 +: 8] = bus[7:0];
      acnt = acnt + 2'h1;
      col = adr[7:0];
      if (acnt == 2'h3 && cmd != 8'h80)
        go_busy();
    end else if (!chip_sel_n) begin
      mem[{a8, col[3:0]}] = bus;
      col = col + 8'h01;
    end
  end
  // Released lines show the inverse of the last word so a stale value cannot pass for a fresh one.
  always @(negedge output_strobe_n) begin
    if (!chip_sel_n) begin
      dq <= #(ACC_NS) (cmd == 8'h70) ? {8'h00, write_protect_n, ready_busy_n, 6'h00} : mem[{a8, col[3:0]}];
      col = col + 8'h01;
    end
  end
  always @(posedge output_strobe_n)
    dq <= #10 ~dq;
endmodule // nfc_flash_model

// ===== test/testbench.sv
// Self-checking bench: AHB-Lite master driving nfc_host against the behavioural flash.
// Assumes the monitor and flash model files are compiled before this one.
`timescale 1ns/1ps
`include "nfc_consts.vh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd, hr_n;
  logic wp = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  wire [31:0] hrdata;
  wire [15:0] io_out, dq, bus;
  wire hreadyout, hresp, cle, ale, cs_n, ws_n, os_n, wp_n, io_oe, rb_n;
  assign bus = io_oe ? io_out : dq;
  initial forever #50 ref_clk = ~ref_clk;
  always @(negedge ref_clk) hr_n = hrdata;
  nfc_host i_nfc_host (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmd_latch_en(cle), .addr_latch_en(ale), .chip_sel_n(cs_n), .write_strobe_n(ws_n), .output_strobe_n(os_n),
    .write_protect_n(wp_n), .io_in(bus), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(rb_n));
  nfc_flash_model i_nfc_flash_model (.chip_sel_n(cs_n), .cmd_latch_en(cle), .addr_latch_en(ale),
    .write_strobe_n(ws_n), .output_strobe_n(os_n), .write_protect_n(wp_n), .bus(bus), .dq(dq), .ready_busy_n(rb_n));
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hr_n;
  endtask
  // Bounded poll of one status bit; a hang ends the run with a failure.
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      ahb(1'b0, 8'h10, 32'h0);
      n++;
    end while (rd[b] !== v && n < 200);
    if (rd[b] !== v) begin
      err_count++;
      stop_test();
    end
  endtask
  task automatic op(input logic [2:0] o, input logic [7:0] c);
    ahb(1'b1, 8'h00, {13'h0, 1'b1, 1'b1, wp, c, 5'h00, o});
    poll(0, 1'b0);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    ahb(1'b0, 8'h10, 32'h0);
    check("stat", rd, 32'h2);
    check("pins", 32'({cs_n, wp_n, io_oe}), 32'h4);
    ahb(1'b0, 8'h14, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask
  task automatic t_prog();
    wp = 1'b1;
    op(`NFC_OP_CMD, 8'h80);
    check("wp pin", 32'(wp_n), 32'h1);
    ahb(1'b1, 8'h04, 32'h3);
    repeat (3) op(`NFC_OP_ADDR, 8'h00);
    ahb(1'b1, 8'h08, 32'hA55A);
    op(`NFC_OP_WR, 8'h00);
    ahb(1'b1, 8'h08, 32'h1234);
    op(`NFC_OP_WR, 8'h00);
    op(`NFC_OP_CMD, 8'h10);
    op(`NFC_OP_CMD, 8'h00);
    check("refused", 32'(rd[3:1]), 32'h6);
    op(`NFC_OP_CMD, 8'h70);
    poll(1, 1'b1);
    op(`NFC_OP_RD, 8'h00);
    ahb(1'b0, 8'h0C, 32'h0);
    check("status", 32'(rd[15:0]), 32'h00C0);
  endtask
  task automatic t_read();
    op(`NFC_OP_CMD, 8'h00);
    ahb(1'b1, 8'h04, 32'h3);
    repeat (3) op(`NFC_OP_ADDR, 8'h00);
    check("read busy", 32'(rd[1]), 32'h0);
    poll(1, 1'b1);
    op(`NFC_OP_RD, 8'h00);
    ahb(1'b0, 8'h0C, 32'h0);
    check("word0", 32'(rd[15:0]), 32'hA55A);
    op(`NFC_OP_RD, 8'h00);
    ahb(1'b0, 8'h0C, 32'h0);
    check("word1", 32'(rd[15:0]), 32'h1234);
    op(`NFC_OP_DESEL, 8'h00);
    check("deselect", 32'(cs_n), 32'h1);
  endtask
  // Page 0 was programmed once already; two more are taken and a fourth is refused.
  task automatic t_limit();
    repeat (2) begin
      op(`NFC_OP_CMD, 8'h10);
      check("prog taken", 32'(rd[3:1]), 32'h2);
      poll(1, 1'b1);
    end
    op(`NFC_OP_CMD, 8'h10);
    check("fourth prog", 32'(rd[3:1]), 32'h7);
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_prog();
    t_read();
    t_limit();
    stop_test();
  end
endmodule // testbench
